// file: hdl/btap_defines.svh
`ifndef BTAP_DEFINES_SVH
`define BTAP_DEFINES_SVH

// instruction register
`define BTAP_IR_W 3
`define BTAP_OP_EXTEST 3'h0
`define BTAP_OP_SAMPLE 3'h1
`define BTAP_OP_IDCODE 3'h2
`define BTAP_OP_SCPT 3'h3
`define BTAP_OP_BYPASS 3'h7
// fixed pattern loaded in capture-ir, low bits 01
`define BTAP_IR_CAPT 3'h1

// identification register; code value is arbitrary, lsb must be 1
`define BTAP_ID_W 32
`define BTAP_ID_CODE 32'h0a5c_3001

// reset value of filtered pins {tck, tms, tdi, trst_n}
`define BTAP_PIN_RST 4'h4

// boundary register split
`define BTAP_NIN 16
`define BTAP_NOUT 16

// timing
`define BTAP_MCLK_NS 40
`define BTAP_TCK_HALF_MIN_NS 160
`define BTAP_TCK_HALF_CYC ((`BTAP_TCK_HALF_MIN_NS) / (`BTAP_MCLK_NS))
// sync chain needs three samples plus agreement per tck level
`define BTAP_TCK_HALF_CYC_MIN 3

`endif

// file: hdl/btap_pkg.sv
package btap_pkg;

    typedef enum logic [15:0] {
        BTAP_TLR = 16'h0001,
        BTAP_RTI = 16'h0002,
        BTAP_SEL_DR = 16'h0004,
        BTAP_CAP_DR = 16'h0008,
        BTAP_SH_DR = 16'h0010,
        BTAP_EX1_DR = 16'h0020,
        BTAP_PAU_DR = 16'h0040,
        BTAP_EX2_DR = 16'h0080,
        BTAP_UPD_DR = 16'h0100,
        BTAP_SEL_IR = 16'h0200,
        BTAP_CAP_IR = 16'h0400,
        BTAP_SH_IR = 16'h0800,
        BTAP_EX1_IR = 16'h1000,
        BTAP_PAU_IR = 16'h2000,
        BTAP_EX2_IR = 16'h4000,
        BTAP_UPD_IR = 16'h8000
    } btap_state_t;

    typedef enum logic [3:0] {
        BTAP_P_BYPASS = 4'h1,
        BTAP_P_IDCODE = 4'h2,
        BTAP_P_BSR = 4'h4,
        BTAP_P_NONE = 4'h8
    } btap_path_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } btap_pins_t;

    typedef struct packed {
        btap_path_t path;
        logic extest;
        logic sample;
        logic scpt;
    } btap_dec_t;

endpackage

// file: hdl/btap_tap.sv
`timescale 1ns/1ps
`include "btap_defines.svh"

// Overview of operation
// - fsm steps on tck rise by tms
// - trst_n low forces reset state once filtered, without tck
// - five tms-high clocks reach reset state
// - reset state forces identification instruction
// - capture-dr loads selected register parallel inputs
// - shift-dr shifts toward lsb, tdi in
// - update-dr latches outputs on tck fall
// - capture-ir loads fixed pattern
// - shift-ir shifts ir and selected register
// - update-ir makes new instruction on fall
// - pause states hold shift contents
// - tdo driven only in shift states
// - bypass gives one-bit tdi-tdo delay
// - extest: boundary captures inputs, drives outputs
// - sample: boundary snapshots pins, no control
// - idcode connects identification register
// - production test loads id into boundary
module btap_tap #(
    parameter int NIN = `BTAP_NIN,
    parameter int NOUT = `BTAP_NOUT,
    parameter logic [`BTAP_ID_W-1:0] ID_CODE = `BTAP_ID_CODE
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire btap_pkg::btap_pins_t jtag_pins,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [NIN-1:0] pin_in,
    input wire logic [NOUT-1:0] core_out,
    output logic [NOUT-1:0] pad_out,
    output logic test_mode
);

    localparam int BSR_W = NIN + NOUT;

    if (BSR_W < `BTAP_ID_W) begin : g_chk_len
        $error("boundary register shorter than identification code");
    end
    if (NIN < 1 || NOUT < 1) begin : g_chk_w
        $error("boundary register needs input and output cells");
    end
    if (`BTAP_TCK_HALF_CYC < `BTAP_TCK_HALF_CYC_MIN) begin : g_chk_tck
        $error("tck too fast for the sampling clock");
    end
    if (ID_CODE[0] != 1'b1) begin : g_chk_id
        $error("identification code lsb must be one");
    end

    // next controller state from tms
    // five tms ones reach reset from anywhere
    function automatic btap_pkg::btap_state_t next_state(input btap_pkg::btap_state_t s, input logic m);
        btap_pkg::btap_state_t n;
        n = btap_pkg::BTAP_TLR;
        unique case (s)
            btap_pkg::BTAP_TLR: begin
                n = m ? btap_pkg::BTAP_TLR : btap_pkg::BTAP_RTI;
            end
            btap_pkg::BTAP_RTI: begin
                n = m ? btap_pkg::BTAP_SEL_DR : btap_pkg::BTAP_RTI;
            end
            btap_pkg::BTAP_SEL_DR: begin
                n = m ? btap_pkg::BTAP_SEL_IR : btap_pkg::BTAP_CAP_DR;
            end
            btap_pkg::BTAP_CAP_DR: begin
                n = m ? btap_pkg::BTAP_EX1_DR : btap_pkg::BTAP_SH_DR;
            end
            btap_pkg::BTAP_SH_DR: begin
                n = m ? btap_pkg::BTAP_EX1_DR : btap_pkg::BTAP_SH_DR;
            end
            btap_pkg::BTAP_EX1_DR: begin
                n = m ? btap_pkg::BTAP_UPD_DR : btap_pkg::BTAP_PAU_DR;
            end
            btap_pkg::BTAP_PAU_DR: begin
                n = m ? btap_pkg::BTAP_EX2_DR : btap_pkg::BTAP_PAU_DR;
            end
            btap_pkg::BTAP_EX2_DR: begin
                n = m ? btap_pkg::BTAP_UPD_DR : btap_pkg::BTAP_SH_DR;
            end
            btap_pkg::BTAP_UPD_DR: begin
                n = m ? btap_pkg::BTAP_SEL_DR : btap_pkg::BTAP_RTI;
            end
            btap_pkg::BTAP_SEL_IR: begin
                n = m ? btap_pkg::BTAP_TLR : btap_pkg::BTAP_CAP_IR;
            end
            btap_pkg::BTAP_CAP_IR: begin
                n = m ? btap_pkg::BTAP_EX1_IR : btap_pkg::BTAP_SH_IR;
            end
            btap_pkg::BTAP_SH_IR: begin
                n = m ? btap_pkg::BTAP_EX1_IR : btap_pkg::BTAP_SH_IR;
            end
            btap_pkg::BTAP_EX1_IR: begin
                n = m ? btap_pkg::BTAP_UPD_IR : btap_pkg::BTAP_PAU_IR;
            end
            btap_pkg::BTAP_PAU_IR: begin
                n = m ? btap_pkg::BTAP_EX2_IR : btap_pkg::BTAP_PAU_IR;
            end
            btap_pkg::BTAP_EX2_IR: begin
                n = m ? btap_pkg::BTAP_UPD_IR : btap_pkg::BTAP_SH_IR;
            end
            btap_pkg::BTAP_UPD_IR: begin
                n = m ? btap_pkg::BTAP_SEL_DR : btap_pkg::BTAP_RTI;
            end
            default: begin
                n = btap_pkg::BTAP_TLR;
            end
        endcase
        return n;
    endfunction

    // instruction decode
    function automatic btap_pkg::btap_dec_t decode(input logic [`BTAP_IR_W-1:0] op);
        btap_pkg::btap_dec_t d;
        d = '{path: btap_pkg::BTAP_P_BYPASS, extest: 1'b0, sample: 1'b0, scpt: 1'b0};
        case (op)
            `BTAP_OP_EXTEST: begin
                d.path = btap_pkg::BTAP_P_BSR;
                d.extest = 1'b1;
            end
            `BTAP_OP_SAMPLE: begin
                d.path = btap_pkg::BTAP_P_BSR;
                d.sample = 1'b1;
            end
            `BTAP_OP_IDCODE: begin
                d.path = btap_pkg::BTAP_P_IDCODE;
            end
            `BTAP_OP_SCPT: begin
                d.path = btap_pkg::BTAP_P_BSR;
                d.scpt = 1'b1;
            end
            default: begin
                d.path = btap_pkg::BTAP_P_BYPASS;
            end
        endcase
        return d;
    endfunction

    btap_pkg::btap_pins_t s1_r, s2_r, s3_r, flt_r, flt_nxt;
    logic tck_d_r;
    logic tck_rise, tck_fall;
    btap_pkg::btap_state_t state_r, state_nxt;
    logic [`BTAP_IR_W-1:0] ir_sh_r;
    logic [`BTAP_IR_W-1:0] ir_r;
    btap_pkg::btap_dec_t dec;
    logic bypass_r;
    logic [`BTAP_ID_W-1:0] id_sh_r;
    logic [BSR_W-1:0] bsr_r;
    logic [NOUT-1:0] upd_r;
    logic dr_out;
    logic shift_dr, shift_ir, cap_dr, cap_ir;

    // three-stage pin sampling
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s1_r <= `BTAP_PIN_RST;
            s2_r <= `BTAP_PIN_RST;
            s3_r <= `BTAP_PIN_RST;
        end else begin
            s1_r <= jtag_pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a pin bit moves once stages two and three agree
    always_comb begin
        flt_nxt = (s2_r & ~(s2_r ^ s3_r)) | (flt_r & (s2_r ^ s3_r));
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            flt_r <= `BTAP_PIN_RST;
            tck_d_r <= 1'b0;
        end else begin
            flt_r <= flt_nxt;
            tck_d_r <= flt_r.tck;
        end
    end

    assign tck_rise = flt_r.tck & ~tck_d_r;
    assign tck_fall = ~flt_r.tck & tck_d_r;

    assign dec = decode(ir_r);
    assign shift_dr = state_r == btap_pkg::BTAP_SH_DR;
    assign shift_ir = state_r == btap_pkg::BTAP_SH_IR;
    assign cap_dr = state_r == btap_pkg::BTAP_CAP_DR;
    assign cap_ir = state_r == btap_pkg::BTAP_CAP_IR;

    always_comb begin
        state_nxt = state_r;
        if (tck_rise) begin
            state_nxt = next_state(state_r, flt_r.tms);
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst || !flt_r.trst_n) begin
            state_r <= btap_pkg::BTAP_TLR;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst || !flt_r.trst_n) begin
            ir_sh_r <= `BTAP_IR_CAPT;
        end else if (tck_rise && cap_ir) begin
            ir_sh_r <= `BTAP_IR_CAPT;
        end else if (tck_rise && shift_ir) begin
            ir_sh_r <= {flt_r.tdi, ir_sh_r[`BTAP_IR_W-1:1]};
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst || !flt_r.trst_n) begin
            ir_r <= `BTAP_OP_IDCODE;
        end else if (state_r == btap_pkg::BTAP_TLR) begin
            ir_r <= `BTAP_OP_IDCODE;
        end else if (tck_fall && state_r == btap_pkg::BTAP_UPD_IR) begin
            ir_r <= ir_sh_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            bypass_r <= 1'b0;
        end else if (tck_rise && dec.path == btap_pkg::BTAP_P_BYPASS) begin
            if (cap_dr) begin
                bypass_r <= 1'b0;
            end else if (shift_dr || shift_ir) begin
                bypass_r <= flt_r.tdi;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            id_sh_r <= ID_CODE;
        end else if (tck_rise && dec.path == btap_pkg::BTAP_P_IDCODE) begin
            if (cap_dr) begin
                id_sh_r <= ID_CODE;
            end else if (shift_dr || shift_ir) begin
                id_sh_r <= {flt_r.tdi, id_sh_r[`BTAP_ID_W-1:1]};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            bsr_r <= '0;
        end else if (tck_rise && dec.path == btap_pkg::BTAP_P_BSR) begin
            if (cap_dr) begin
                if (dec.scpt) begin
                    bsr_r <= BSR_W'(ID_CODE);
                end else if (dec.extest) begin
                    bsr_r <= {pad_out, pin_in};
                end else begin
                    bsr_r <= {core_out, pin_in};
                end
            end else if (shift_dr || shift_ir) begin
                bsr_r <= {flt_r.tdi, bsr_r[BSR_W-1:1]};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst || !flt_r.trst_n) begin
            upd_r <= '0;
        end else if (tck_fall && state_r == btap_pkg::BTAP_UPD_DR && dec.path == btap_pkg::BTAP_P_BSR) begin
            upd_r <= bsr_r[BSR_W-1:NIN];
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pad_out <= '0;
            test_mode <= 1'b0;
        end else begin
            pad_out <= dec.extest ? upd_r : core_out;
            test_mode <= dec.extest;
        end
    end

    // serial source of the selected data path
    always_comb begin
        dr_out = bypass_r;
        unique case (dec.path)
            btap_pkg::BTAP_P_IDCODE: begin
                dr_out = id_sh_r[0];
            end
            btap_pkg::BTAP_P_BSR: begin
                dr_out = bsr_r[0];
            end
            btap_pkg::BTAP_P_BYPASS: begin
                dr_out = bypass_r;
            end
            default: begin
                dr_out = bypass_r;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst || !flt_r.trst_n) begin
            tdo <= 1'b0;
        end else if (tck_fall) begin
            tdo <= shift_ir ? ir_sh_r[0] : dr_out;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst || !flt_r.trst_n) begin
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe <= shift_ir || shift_dr;
        end
    end

endmodule

// file: verification/btap_tap_sva.sv
`timescale 1ns/1ps
module btap_chk #(
    parameter int NIN = 16,
    parameter int NOUT = 16
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire btap_pkg::btap_pins_t jtag_pins,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic [NIN-1:0] pin_in,
    input wire logic [NOUT-1:0] core_out,
    input wire logic [NOUT-1:0] pad_out,
    input wire logic test_mode
);
    logic tck_q_r;
    logic tms_last_r;
    logic tms_fall_r;
    logic [2:0] ones_r;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    always_ff @(posedge mclk) begin
        tck_q_r <= jtag_pins.tck;
    end
    // tms seen at each tck rise, run of ones; kept at the next fall
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tms_last_r <= 1'b1;
            tms_fall_r <= 1'b1;
            ones_r <= 3'h0;
        end else if (jtag_pins.tck && !tck_q_r) begin
            tms_last_r <= jtag_pins.tms;
            ones_r <= !jtag_pins.tms ? 3'h0 : (ones_r == 3'h5 ? 3'h5 : ones_r + 3'h1);
        end else if (!jtag_pins.tck && tck_q_r) begin
            tms_fall_r <= tms_last_r;
        end
    end
    property p_tdo_edge; $changed(tdo) |-> !$past(jtag_pins.tck, 3); endproperty
    a_tdo_edge: assert property (p_tdo_edge) else $error("tdo moved in tck high");
    property p_oe_edge; $changed(tdo_oe) |-> !$past(jtag_pins.tck, 3); endproperty
    a_oe_edge: assert property (p_oe_edge) else $error("tdo_oe moved in tck high");
    property p_oe_entry; $rose(tdo_oe) |-> !tms_fall_r; endproperty
    a_oe_entry: assert property (p_oe_entry) else $error("tdo_oe rose outside shift");
    property p_trst_out; !jtag_pins.trst_n [*6] |-> !tdo_oe && !tdo; endproperty
    a_trst_out: assert property (p_trst_out) else $error("tdo driven under trst");
    property p_trst_mode; !jtag_pins.trst_n [*7] |-> !test_mode; endproperty
    a_trst_mode: assert property (p_trst_mode) else $error("test_mode under trst");
    property p_pad_follow; !test_mode && !$past(test_mode) && $past(nrst) |-> pad_out == $past(core_out); endproperty
    a_pad_follow: assert property (p_pad_follow) else $error("pad_out not core_out");
    property p_pad_upd; test_mode && $past(test_mode) && $changed(pad_out) |-> !$past(jtag_pins.tck, 3); endproperty
    a_pad_upd: assert property (p_pad_upd) else $error("pad_out moved in tck high");
    property p_ir_upd; $rose(test_mode) |-> !$past(jtag_pins.tck, 3); endproperty
    a_ir_upd: assert property (p_ir_upd) else $error("instruction took effect in tck high");
    property p_tms5; ones_r == 3'h5 |-> ##[0:12] (!tdo_oe && !test_mode); endproperty
    a_tms5: assert property (p_tms5) else $error("five tms ones did not reset");
endmodule

bind btap_tap btap_chk #(.NIN(NIN), .NOUT(NOUT)) u_chk (.mclk(mclk), .nrst(nrst), .jtag_pins(jtag_pins),
    .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .core_out(core_out), .pad_out(pad_out), .test_mode(test_mode));

// file: verification/btap_tester.sv
`timescale 1ns/1ps
module btap_tester (
    input wire logic mclk,
    input wire logic tdo,
    input wire logic tdo_oe,
    output btap_pkg::btap_pins_t pins
);
    logic last_r = 1'b0;
    // released line shows inverse of last bit
    wire tdo_w = tdo_oe ? tdo : ~last_r;
    initial pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b1};
    always @(posedge mclk) begin
        if (tdo_oe) last_r <= tdo;
    end
    // one tck period of 8 mclk, tdo taken before next fall
    task automatic clk(input logic tms, input logic tdi, output logic o);
        @(posedge mclk);
        pins.tck <= 1'b0;
        pins.tms <= tms;
        pins.tdi <= tdi;
        repeat (4) @(posedge mclk);
        pins.tck <= 1'b1;
        repeat (3) @(posedge mclk);
        o = tdo_w;
    endtask
    task automatic shift_ir(input logic [2:0] op, output logic [2:0] cap);
        logic o;
        for (int i = 0; i < 4; i++) clk(i < 2, 1'b0, o);
        for (int i = 0; i < 3; i++) clk(i == 2, op[i], cap[i]);
        clk(1'b1, 1'b0, o);
        clk(1'b0, 1'b0, o);
    endtask
    task automatic shift_dr(input logic [31:0] din, input logic pz, output logic [31:0] dout);
        logic o;
        for (int i = 0; i < 3; i++) clk(i == 0, 1'b0, o);
        for (int i = 0; i < 32; i++) begin
            clk(i == 31 || (pz && i == 15), din[i], dout[i]);
            if (pz && i == 15) begin
                for (int j = 0; j < 4; j++) clk(j == 2, 1'b0, o);
            end
        end
        clk(1'b1, 1'b0, o);
        clk(1'b0, 1'b0, o);
    endtask
    task automatic trst();
        @(posedge mclk);
        pins.tck <= 1'b0;
        repeat (2) @(posedge mclk);
        pins.trst_n <= 1'b0;
        repeat (8) @(posedge mclk);
        pins.trst_n <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask
endmodule

// file: verification/test_btap_tap.sv
`timescale 1ns/1ps
`include "btap_defines.svh"
module test_btap_tap;
    // arbitrary code, lsb set
    localparam logic [31:0] ID = 32'h5a3c_0f01;
    localparam logic [31:0] D = 32'hc3a5_96e1;
    logic mclk;
    logic nrst;
    logic [15:0] pin_in;
    logic [15:0] core_out;
    logic [15:0] pad_out;
    btap_pkg::btap_pins_t jtag_pins;
    logic tdo;
    logic tdo_oe;
    logic test_mode;
    logic o;
    logic [2:0] cap;
    logic [31:0] dout;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    btap_tap #(.NIN(16), .NOUT(16), .ID_CODE(ID)) dut (.mclk(mclk), .nrst(nrst), .jtag_pins(jtag_pins),
        .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .core_out(core_out), .pad_out(pad_out), .test_mode(test_mode));
    btap_tester u_tst (.mclk(mclk), .tdo(tdo), .tdo_oe(tdo_oe), .pins(jtag_pins));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic final_report();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic t_id();
        u_tst.clk(1'b0, 1'b0, o);
        u_tst.shift_dr(32'h0, 1'b0, dout);
        chk("idcode", ID, dout);
    endtask
    task automatic t_bypass();
        for (int i = 0; i < 4; i++) begin
            u_tst.shift_ir(i == 0 ? `BTAP_OP_BYPASS : 3'(3 + i), cap);
            chk("ir_capture", 32'(`BTAP_IR_CAPT), 32'(cap));
            u_tst.shift_dr(D, 1'b0, dout);
            chk("bypass", D << 1, dout);
        end
    endtask
    task automatic t_extest();
        pin_in <= 16'hbeef;
        core_out <= 16'h1357;
        u_tst.shift_ir(`BTAP_OP_EXTEST, cap);
        chk("test_mode", 32'h1, 32'(test_mode));
        u_tst.shift_dr(32'h6c91_0000, 1'b0, dout);
        repeat (8) @(posedge mclk);
        chk("pad_drive", 32'h6c91, 32'(pad_out));
        u_tst.shift_dr(32'h0, 1'b1, dout);
        chk("ext_capture", 32'h6c91_beef, dout);
    endtask
    task automatic t_sample();
        core_out <= 16'h2468;
        u_tst.shift_ir(`BTAP_OP_SAMPLE, cap);
        chk("test_mode", 32'h0, 32'(test_mode));
        u_tst.shift_dr(32'hffff_ffff, 1'b0, dout);
        chk("smp_capture", 32'h2468_beef, dout);
        repeat (8) @(posedge mclk);
        chk("pad_follow", 32'h2468, 32'(pad_out));
    endtask
    task automatic t_scpt();
        u_tst.shift_ir(`BTAP_OP_SCPT, cap);
        u_tst.shift_dr(32'h0, 1'b0, dout);
        chk("scpt_capture", ID, dout);
    endtask
    task automatic t_trst();
        u_tst.shift_ir(`BTAP_OP_EXTEST, cap);
        u_tst.trst();
        chk("trst_mode", 32'h0, 32'(test_mode));
        t_id();
    endtask
    task automatic t_tms5();
        u_tst.shift_ir(`BTAP_OP_EXTEST, cap);
        for (int i = 0; i < 3; i++) u_tst.clk(i == 0, 1'b0, o);
        repeat (5) u_tst.clk(1'b1, 1'b0, o);
        repeat (8) @(posedge mclk);
        chk("tms5_mode", 32'h0, 32'(test_mode));
        t_id();
    endtask
    initial begin
        nrst = 1'b0;
        pin_in = 16'h0;
        core_out = 16'h0;
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        repeat (10) @(posedge mclk);
        t_id();
        t_bypass();
        t_extest();
        t_sample();
        t_scpt();
        t_trst();
        t_tms5();
        final_report();
    end
endmodule
